// ---- core/smc_consts.vh ----
// constants for the static memory bus controller
// assumes every includer runs on one clock with all inputs synchronous to it
// Function
// R1 - six active-low chip selects share one 26-bit external address bus
// R2 - each chip select decodes its own 64-megabyte address window
// R3 - 32-bit data bus serves 8, 16 or 32-bit devices per region
// R4 - separate read and write strobes drive memories with no glue logic
// R5 - an active-low wait input stretches the access while it stays low
// R6 - slow clock mode swaps programmed waveforms for fixed slow waveforms
// R7 - page-mode burst reads with page size from 4 to 32 bytes
// R8 - read strobe and chip select setup, pulse, hold programmable per chip select
// R9 - write strobe and chip select setup, pulse, hold programmable per chip select
// R10 - data float time after a read programmable per chip select
// R11 - word, halfword and byte transfers split or masked to device width
// R12 - 16/32-bit buses use per-lane write strobes or common strobe with selects
// R13 - chip selects, strobes, byte selects and wait input are all active low
// R14 - lowest address pin is lane-0 select on wide buses, address bit on 8-bit; the code holds it high on wide buses in byte-write style
// R15 - one pin is address bit one, lane-2 write strobe or lane-2 select
// R16 - lane-1 and lane-3 pins are write strobes or byte selects per style
// R17 - all strobe and chip select timings count whole clock cycles per chip select
// R18 - software programs every pulse to at least one cycle
// R19 - cycle length is shared; hold equals cycle minus setup minus pulse
// R20 - small devices repeat across the window since upper bits are ignored
// R21 - at most one chip select is active, the one holding the access
`ifndef STATIC_MEM_CONSTS_VH
`define STATIC_MEM_CONSTS_VH
`define CS_COUNT    3'h6
`define CS_LSB      26
`define DW_8        2'h0
`define DW_16       2'h1
`define DW_32       2'h2
`define SZ_WORD     2'h2
`define PAGE_LSB    2
`define SLOW_SETUP  1
`define SLOW_PULSE  1
`define SLOW_CYCLE  3
`endif

// ---- core/strobe_window.v ----
// one strobe window: active from setup for pulse cycles of a count
// assumes the count restarts at zero at each beat
`timescale 1ns/1ps
`default_nettype none
module strobe_window #(
  parameter TW = 7
)(
  input  wire [TW-1:0] i_cnt,
  input  wire [TW-1:0] i_setup,
  input  wire [TW-1:0] i_pulse,
  output wire          o_on
);
  wire [TW:0] stop;
  // ***************************************
  // window compare
  // ***************************************
  assign stop = {1'b0, i_setup} + {1'b0, i_pulse};
  assign o_on = ({1'b0, i_cnt} >= {1'b0, i_setup}) && ({1'b0, i_cnt} < stop); // [R17]
endmodule
`default_nettype wire

// ---- core/lane_pin_mux.v ----
// multiplexed lane pins: address bits, write strobes and byte selects
// assumes byte enables and address bits are stable for the whole beat
`timescale 1ns/1ps
`default_nettype none
`include "smc_consts.vh"
module lane_pin_mux (
  input  wire       i_busy,
  input  wire       i_wr_on,
  input  wire [3:0] i_be,
  input  wire       i_a0,
  input  wire       i_a1,
  input  wire [1:0] i_devw,
  input  wire       i_byte_write,
  output reg        o_lane0_select_n,
  output reg        o_write_strobe_n,
  output reg        o_lane1_select_n,
  output reg        o_lane2_select_n,
  output reg        o_lane3_select_n
);
  wire [3:0] sel;
  wire [3:0] wrl;
  // ***************************************
  // pin translation
  // ***************************************
  assign sel = i_busy ? i_be : 4'h0;
  assign wrl = i_wr_on ? i_be : 4'h0;
  always @* begin
    o_lane3_select_n = 1'b1;
    o_lane1_select_n = 1'b1;
    if (i_devw == `DW_8) begin
      o_lane0_select_n = i_a0; // [R14]
      o_write_strobe_n = ~i_wr_on; // [R4]
      o_lane2_select_n = i_a1; // [R15]
    end else if (i_byte_write) begin
      o_lane0_select_n = 1'b1; // [R12]
      o_write_strobe_n = ~wrl[0]; // [R12] [R13]
      o_lane1_select_n = ~wrl[1]; // [R16]
      o_lane2_select_n = (i_devw == `DW_32) ? ~wrl[2] : i_a1; // [R15]
      if (i_devw == `DW_32) begin
        o_lane3_select_n = ~wrl[3]; // [R16]
      end
    end else begin
      o_lane0_select_n = ~sel[0]; // [R14] [R13]
      o_write_strobe_n = ~i_wr_on; // [R12]
      o_lane1_select_n = ~sel[1]; // [R16]
      o_lane2_select_n = (i_devw == `DW_32) ? ~sel[2] : i_a1; // [R15]
      if (i_devw == `DW_32) begin
        o_lane3_select_n = ~sel[3]; // [R16]
      end
    end
  end
endmodule
`default_nettype wire

// ---- core/static_memory_bus_controller.v ----
// static memory bus controller: system requests to external static memory cycles
// assumes all inputs synchronous to i_ref_clk; configuration held steady while busy
`timescale 1ns/1ps
`default_nettype none
`include "smc_consts.vh"
module static_memory_bus_controller #(
  parameter NUM_CS = 6,
  parameter TW     = 7,
  parameter FW     = 4
)(
  input  wire                 i_ref_clk,
  input  wire                 i_rstn,
  input  wire                 i_req,
  input  wire                 i_write,
  input  wire [1:0]           i_size,
  input  wire [28:0]          i_addr,
  input  wire [31:0]          i_wdata,
  output wire                 o_ready,
  output reg                  o_done,
  output reg                  o_error,
  output reg  [31:0]          o_rdata,
  input  wire [NUM_CS*TW-1:0] i_rd_setup,
  input  wire [NUM_CS*TW-1:0] i_rd_pulse,
  input  wire [NUM_CS*TW-1:0] i_rd_cycle,
  input  wire [NUM_CS*TW-1:0] i_cs_rd_setup,
  input  wire [NUM_CS*TW-1:0] i_cs_rd_pulse,
  input  wire [NUM_CS*TW-1:0] i_wr_setup,
  input  wire [NUM_CS*TW-1:0] i_wr_pulse,
  input  wire [NUM_CS*TW-1:0] i_wr_cycle,
  input  wire [NUM_CS*TW-1:0] i_cs_wr_setup,
  input  wire [NUM_CS*TW-1:0] i_cs_wr_pulse,
  input  wire [NUM_CS*FW-1:0] i_float,
  input  wire [NUM_CS*2-1:0]  i_bus_width,
  input  wire [NUM_CS-1:0]    i_byte_write,
  input  wire [NUM_CS-1:0]    i_page_mode,
  input  wire [NUM_CS*2-1:0]  i_page_size,
  input  wire                 i_slow_clock,
  output wire [NUM_CS-1:0]    o_chip_select_n,
  output wire                 o_read_strobe_n,
  output wire                 o_write_strobe_n,
  output wire                 o_lane0_select_n,
  output wire                 o_lane1_select_n,
  output wire                 o_lane2_select_n,
  output wire                 o_lane3_select_n,
  output reg  [25:2]          o_addr,
  output reg  [31:0]          o_data,
  output reg                  o_data_oe,
  input  wire [31:0]          i_data,
  input  wire                 i_wait_request_n
);
  localparam ST_IDLE = 1'b0;
  localparam ST_BEAT = 1'b1;

  // ***************************************
  // fixed slow-rate waveform
  // ***************************************
  localparam [31:0] SLOW_SETUP32 = `SLOW_SETUP;
  localparam [31:0] SLOW_PULSE32 = `SLOW_PULSE;
  localparam [31:0] SLOW_CYCLE32 = `SLOW_CYCLE;

  // ***************************************
  // helpers
  // ***************************************
  function [TW-1:0] pick_t;
    input [NUM_CS*TW-1:0] v;
    input [2:0]           idx;
    begin
      pick_t = v[idx*TW +: TW];
    end
  endfunction

  function [2:0] beat_bytes;
    input [1:0] size;
    input [1:0] dw;
    begin
      beat_bytes = (size >= dw) ? (3'h1 << dw) : (3'h1 << size);
    end
  endfunction

  function [1:0] lane_off;
    input [1:0] dw;
    input [1:0] a;
    begin
      lane_off = (dw == `DW_32) ? a : ((dw == `DW_16) ? {1'b0, a[0]} : 2'h0);
    end
  endfunction

  function [4:0] chunk_shift;
    input [1:0] k;
    input [1:0] dw;
    begin
      chunk_shift = {k, 3'h0} << dw;
    end
  endfunction

  function [31:0] read_lanes;
    input [31:0] d;
    input [1:0]  o;
    input [2:0]  n;
    input [1:0]  k;
    input [1:0]  dw;
    begin
      read_lanes = ((d >> {o, 3'h0}) & ~(32'hffffffff << {n, 3'h0})) << chunk_shift(k, dw);
    end
  endfunction

  // ***************************************
  // state
  // ***************************************
  reg          state;
  reg [2:0]    cs_idx;
  reg [2:0]    last_cs;
  reg [1:0]    devw;
  reg          bw;
  reg          wr;
  reg [1:0]    size;
  reg [25:0]   addr;
  reg [31:0]   wdata;
  reg [31:0]   racc;
  reg [1:0]    beat;
  reg [1:0]    last_beat;
  reg [TW-1:0] cnt;
  reg [TW-1:0] s_setup;
  reg [TW-1:0] s_pulse;
  reg [TW-1:0] s_cycle;
  reg [TW-1:0] c_setup;
  reg [TW-1:0] c_pulse;
  reg          pmode;
  reg [1:0]    psize;
  reg          cont;
  reg [FW-1:0] float_cnt;

  wire [2:0]    req_cs;
  wire [1:0]    req_dw;
  wire [2:0]    nbytes;
  wire [1:0]    off;
  wire [3:0]    be;
  wire [TW-1:0] e_setup;
  wire [TW-1:0] e_cycle;
  wire [TW-1:0] e_csetup;
  wire [TW-1:0] e_cpulse;
  wire [TW:0]   pulse_end;
  wire          last_pulse;
  wire          beat_end;
  wire          hold;
  wire          str_on;
  wire          cs_on;
  wire          busy;
  wire [25:0]   next_addr;
  wire          same_page;
  wire [1:0]    next_last;
  wire [31:0]   rd_chunk;

  assign req_cs    = i_addr[`CS_LSB +: 3]; // [R2]
  assign req_dw    = i_bus_width[req_cs*2 +: 2];
  assign next_last = (i_size > req_dw) ? ((2'h1 << (i_size - req_dw)) - 2'h1) : 2'h0; // [R11]
  assign busy      = (state == ST_BEAT);
  assign nbytes    = beat_bytes(size, devw);
  assign off       = lane_off(devw, addr[1:0]);
  assign be        = (~(4'hf << nbytes)) << off; // [R11]
  assign rd_chunk  = read_lanes(i_data, off, nbytes, beat, devw); // [R11]

  // page continuation drops setup and hold, so strobe and chip select stay low across continued beats
  assign e_setup   = cont ? {TW{1'b0}} : s_setup; // [R7]
  assign e_cycle   = cont ? s_pulse : s_cycle; // [R7]
  assign e_csetup  = cont ? {TW{1'b0}} : c_setup;
  assign e_cpulse  = cont ? s_pulse : c_pulse;

  assign pulse_end  = {1'b0, e_setup} + {1'b0, s_pulse};
  assign last_pulse = ({1'b0, cnt} + {{TW{1'b0}}, 1'b1}) == pulse_end;
  assign hold       = busy && last_pulse && !i_wait_request_n; // [R5] [R13]
  // hold time is what the cycle leaves after setup and pulse
  assign beat_end   = ({1'b0, cnt} + {{TW{1'b0}}, 1'b1} >= {1'b0, e_cycle})
                      && ({1'b0, cnt} + {{TW{1'b0}}, 1'b1} >= pulse_end); // [R19]
  assign next_addr  = addr + (26'h1 << devw);
  assign same_page  = (next_addr >> (`PAGE_LSB + psize)) == (addr >> (`PAGE_LSB + psize)); // [R7]

  // reads to the same chip select may start during float; others wait
  assign o_ready = (state == ST_IDLE)
                   && ((float_cnt == {FW{1'b0}}) || (!i_write && req_cs == last_cs)); // [R10]

  // ***************************************
  // strobe windows
  // ***************************************
  strobe_window #(.TW(TW)) u_strobe (
    .i_cnt   (cnt),
    .i_setup (e_setup),
    .i_pulse (s_pulse),
    .o_on    (str_on)
  );

  strobe_window #(.TW(TW)) u_select (
    .i_cnt   (cnt),
    .i_setup (e_csetup),
    .i_pulse (e_cpulse),
    .o_on    (cs_on)
  );

  // ***************************************
  // pins
  // ***************************************
  assign o_chip_select_n = (busy && cs_on) ? ~({{(NUM_CS-1){1'b0}}, 1'b1} << cs_idx)
                                           : {NUM_CS{1'b1}}; // [R1] [R21] [R13]
  assign o_read_strobe_n = ~(busy && str_on && !wr); // [R4] [R8]

  lane_pin_mux u_lanes (
    .i_busy           (busy),
    .i_wr_on          (busy && str_on && wr),
    .i_be             (be),
    .i_a0             (addr[0]),
    .i_a1             (addr[1]),
    .i_devw           (devw),
    .i_byte_write     (bw),
    .o_lane0_select_n (o_lane0_select_n),
    .o_write_strobe_n (o_write_strobe_n),
    .o_lane1_select_n (o_lane1_select_n),
    .o_lane2_select_n (o_lane2_select_n),
    .o_lane3_select_n (o_lane3_select_n)
  );

  // ***************************************
  // access sequencer
  // ***************************************
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state     <= ST_IDLE;
      cs_idx    <= 3'h0;
      last_cs   <= 3'h0;
      devw      <= `DW_8;
      bw        <= 1'b0;
      wr        <= 1'b0;
      size      <= 2'h0;
      addr      <= 26'h0;
      wdata     <= 32'h0;
      racc      <= 32'h0;
      beat      <= 2'h0;
      last_beat <= 2'h0;
      cnt       <= {TW{1'b0}};
      s_setup   <= {TW{1'b0}};
      s_pulse   <= {TW{1'b0}};
      s_cycle   <= {TW{1'b0}};
      c_setup   <= {TW{1'b0}};
      c_pulse   <= {TW{1'b0}};
      pmode     <= 1'b0;
      psize     <= 2'h0;
      cont      <= 1'b0;
      float_cnt <= {FW{1'b0}};
      o_done    <= 1'b0;
      o_error   <= 1'b0;
      o_rdata   <= 32'h0;
      o_addr    <= 24'h0;
      o_data    <= 32'h0;
      o_data_oe <= 1'b0;
    end else begin
      o_done  <= 1'b0;
      o_error <= 1'b0;
      if (float_cnt != {FW{1'b0}}) begin
        float_cnt <= float_cnt - {{(FW-1){1'b0}}, 1'b1};
      end
      case (state)
        ST_IDLE: begin
          if (i_req && o_ready) begin
            if (req_cs >= `CS_COUNT) begin
              o_done  <= 1'b1;
              o_error <= 1'b1;
            end else begin
              state     <= ST_BEAT;
              cs_idx    <= req_cs;
              last_cs   <= req_cs;
              devw      <= req_dw; // [R3]
              bw        <= i_byte_write[req_cs];
              wr        <= i_write;
              size      <= i_size;
              addr      <= i_addr[25:0]; // [R20]
              o_addr    <= i_addr[25:2];
              wdata     <= i_wdata;
              racc      <= 32'h0;
              beat      <= 2'h0;
              last_beat <= next_last; // [R11]
              cnt       <= {TW{1'b0}};
              cont      <= 1'b0;
              pmode     <= i_page_mode[req_cs];
              psize     <= i_page_size[req_cs*2 +: 2];
              if (i_slow_clock) begin
                s_setup <= SLOW_SETUP32[TW-1:0]; // [R6]
                s_pulse <= SLOW_PULSE32[TW-1:0]; // [R6]
                s_cycle <= SLOW_CYCLE32[TW-1:0]; // [R6]
                c_setup <= SLOW_SETUP32[TW-1:0];
                c_pulse <= SLOW_PULSE32[TW-1:0];
              end else if (i_write) begin
                s_setup <= pick_t(i_wr_setup, req_cs); // [R9]
                s_pulse <= pick_t(i_wr_pulse, req_cs); // [R9]
                s_cycle <= pick_t(i_wr_cycle, req_cs); // [R9]
                c_setup <= pick_t(i_cs_wr_setup, req_cs); // [R9]
                c_pulse <= pick_t(i_cs_wr_pulse, req_cs); // [R9]
              end else begin
                s_setup <= pick_t(i_rd_setup, req_cs); // [R8]
                s_pulse <= pick_t(i_rd_pulse, req_cs); // [R8]
                s_cycle <= pick_t(i_rd_cycle, req_cs); // [R8] [R19]
                c_setup <= pick_t(i_cs_rd_setup, req_cs); // [R8]
                c_pulse <= pick_t(i_cs_rd_pulse, req_cs); // [R8]
              end
              o_data    <= i_wdata << {lane_off(req_dw, i_addr[1:0]), 3'h0}; // [R11]
              o_data_oe <= i_write;
            end
          end
        end
        ST_BEAT: begin
          if (!wr && last_pulse && i_wait_request_n) begin
            racc <= racc | rd_chunk; // [R11]
          end
          if (hold) begin
            cnt <= cnt; // [R5]
          end else if (!beat_end) begin
            cnt <= cnt + {{(TW-1){1'b0}}, 1'b1}; // [R17]
          end else if (beat == last_beat) begin
            state     <= ST_IDLE;
            o_done    <= 1'b1;
            o_data_oe <= 1'b0;
            cont      <= 1'b0;
            if (!wr) begin
              // after hold cycles the bus floats, so only a pulse-ending edge adds data
              if (last_pulse) begin
                o_rdata <= racc | rd_chunk; // [R11]
              end else begin
                o_rdata <= racc;
              end
              float_cnt <= i_float[cs_idx*FW +: FW]; // [R10]
            end
          end else begin
            beat   <= beat + 2'h1;
            addr   <= next_addr;
            o_addr <= next_addr[25:2];
            cnt    <= {TW{1'b0}};
            cont   <= pmode && !wr && !i_slow_clock && same_page; // [R7]
            o_data <= (wdata >> chunk_shift(beat + 2'h1, devw)) << {lane_off(devw, next_addr[1:0]), 3'h0};
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- verification/smc_monitor.sv ----
// checker of the static memory controller pin behaviour
// assumes it is bound into the controller top, one clock
`timescale 1ns/1ps
`default_nettype none
module pin_rule_monitor #(
  parameter NUM_CS = 6
)(
  input wire logic              i_ref_clk,
  input wire logic              i_rstn,
  input wire logic              i_req,
  input wire logic [28:0]       i_addr,
  input wire logic [NUM_CS-1:0] i_page_mode,
  input wire logic              i_slow_clock,
  input wire logic              i_wait_request_n,
  input wire logic              o_ready,
  input wire logic              o_done,
  input wire logic              o_error,
  input wire logic [NUM_CS-1:0] o_chip_select_n,
  input wire logic              o_read_strobe_n,
  input wire logic              o_write_strobe_n,
  input wire logic              o_data_oe
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  // ********
  // pin relations
  // ********
  chk_one_select: assert property ($countones(~o_chip_select_n) <= 1)
    else $error("more than one chip select low");
  chk_rw_apart: assert property (!(!o_read_strobe_n && o_data_oe))
    else $error("read strobe low in a write");
  chk_unmapped_cs: assert property (i_req && o_ready && i_addr[28:26] > 3'h5
    |=> o_done && o_error && &o_chip_select_n) else $error("unmapped select not refused");
  chk_rd_wait_hold: assert property (!o_read_strobe_n && !i_wait_request_n
    |=> !o_read_strobe_n) else $error("read strobe released during wait");
  chk_wr_wait_hold: assert property (!o_write_strobe_n && !i_wait_request_n
    |=> !o_write_strobe_n) else $error("write strobe released during wait");
  chk_busy_no_take: assert property (!(&o_chip_select_n) || !o_read_strobe_n
    |-> !o_ready) else $error("ready while an access runs");
  chk_write_drives: assert property (!o_write_strobe_n |-> o_data_oe)
    else $error("write strobe without data drive");
  chk_slow_pulse: assert property (i_slow_clock && i_page_mode == 0
    && $fell(o_read_strobe_n) && i_wait_request_n |=> o_read_strobe_n)
    else $error("slow read pulse not one cycle");
  cover property (o_done && !o_error);
  cover property (!o_read_strobe_n && !i_wait_request_n);
  cover property (o_error);
  cover property (i_slow_clock && !o_write_strobe_n);
endmodule
`default_nettype wire

// ---- verification/sram_model.sv ----
// static memory at the far side: 1 KB, stretches strobes via wait
// assumes width and write style per select come from the bench
`timescale 1ns/1ps
`default_nettype none
module sram_model (
  input wire logic        i_clk,
  input wire logic [5:0]  i_cs_n,
  input wire logic        i_rd_n,
  input wire logic        i_wr_n,
  input wire logic        i_sel0,
  input wire logic [3:1]  i_sel_n,
  input wire logic [25:2] i_addr,
  input wire logic [31:0] i_dq,
  input wire logic        i_oe,
  input wire logic [11:0] i_width,
  input wire logic [5:0]  i_bwr,
  input wire logic [1:0]  i_stall,
  output logic     [31:0] o_q,
  output logic            o_wait_n
);
  logic [7:0]  mem [0:1023];
  logic [9:0]  ix [0:3];
  logic [31:0] last = 0;
  logic [3:0]  en;
  logic [3:0]  sel;
  logic [1:0]  dw;
  logic        act;
  int          w = 0;
  initial for (int i = 0; i < 1024; i++) mem[i] = i[7:0] ^ 8'h5a;
  always_comb begin
    int c;
    c = 0;
    for (int k = 0; k < 6; k++) if (!i_cs_n[k]) c = k;
    dw = i_width[2*c+:2];
    sel = {i_sel_n, i_sel0};
    o_q = ~last;
    for (int k = 0; k < 4; k++) begin
      // lowest pins carry address bits on narrow buses
      ix[k] = dw == 2'h0 ? {i_addr[9:2], i_sel_n[2], i_sel0} :
              dw == 2'h1 ? {i_addr[9:2], i_sel_n[2], k[0]} : {i_addr[9:2], k[1:0]};
      // per-lane strobes or common strobe with selects
      en[k] = i_oe && k < (1 << dw) && ~&i_cs_n && ((i_bwr[c] && dw != 2'h0) ?
              !(k == 0 ? i_wr_n : sel[k]) : (!i_wr_n && (dw == 2'h0 || !sel[k])));
      if (!i_rd_n && ~&i_cs_n && k < (1 << dw)) o_q[8*k+:8] = mem[ix[k]];
    end
    act = ~&i_cs_n && (!i_rd_n || |en);
    // hold wait low for the first stall cycles of a strobe
    o_wait_n = !(act && w < i_stall);
  end
  always @(posedge i_clk) begin
    last <= o_q;
    w <= act ? w + 1 : 0;
    for (int j = 0; j < 4; j++) if (en[j]) mem[ix[j]] <= i_dq[8*j+:8];
  end
endmodule
`default_nettype wire

// ---- verification/tb_static_memory_bus_controller.sv ----
// self-checking bench for the static memory bus controller
// assumes the sram model at the pins and a byte mirror here
`timescale 1ns/1ps
`default_nettype none
module tb_static_memory_bus_controller;
  localparam NUM_CS = 6;
  localparam TW     = 7;
  logic i_ref_clk = 0, i_rstn = 0, i_req = 0, i_write = 0, i_slow_clock = 0;
  logic [1:0] i_size = 0, stl = 0;
  logic [28:0] i_addr = 0;
  logic [31:0] i_wdata = 0, o_rdata, o_data, i_data;
  logic [NUM_CS*TW-1:0] i_rd_setup, i_rd_pulse, i_rd_cycle, i_cs_rd_setup, i_cs_rd_pulse;
  logic [NUM_CS*TW-1:0] i_wr_setup, i_wr_pulse, i_wr_cycle, i_cs_wr_setup, i_cs_wr_pulse;
  logic [23:0] i_float;
  logic [11:0] i_bus_width = 12'h45a, i_page_size;
  logic [5:0] i_byte_write = 6'h0a, i_page_mode = 6'h20, o_chip_select_n;
  logic o_ready, o_done, o_error, o_read_strobe_n, o_write_strobe_n, o_data_oe;
  logic o_lane0_select_n, o_lane1_select_n, o_lane2_select_n, o_lane3_select_n;
  logic i_wait_request_n;
  logic [25:2] o_addr;
  logic [7:0] mem [0:1023];
  int su [2][6], pu [2][6], cy [2][6];
  int error_cnt = 0, n_compared = 0;
  static_memory_bus_controller #(.NUM_CS(NUM_CS), .TW(TW), .FW(4)) uut (.*);
  sram_model part (.i_clk(i_ref_clk), .i_cs_n(o_chip_select_n), .i_rd_n(o_read_strobe_n),
    .i_wr_n(o_write_strobe_n), .i_sel0(o_lane0_select_n),
    .i_sel_n({o_lane3_select_n, o_lane2_select_n, o_lane1_select_n}), .i_addr(o_addr),
    .i_dq(o_data), .i_oe(o_data_oe), .i_width(i_bus_width), .i_bwr(i_byte_write),
    .i_stall(stl), .o_q(i_data), .o_wait_n(i_wait_request_n));
  initial forever #2.5 i_ref_clk = ~i_ref_clk;
  // ********
  // checking and closing
  // ********
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ********
  // random timing per select, held for the run
  // ********
  task automatic cfg;
    for (int c = 0; c < NUM_CS; c++) begin
      for (int d = 0; d < 2; d++) begin
        su[d][c] = $urandom_range(3);
        pu[d][c] = $urandom_range(4, 1);
        cy[d][c] = su[d][c] + pu[d][c] + $urandom_range(2, 1);
      end
      i_rd_setup[c*TW+:TW] = TW'(su[0][c]);
      i_rd_pulse[c*TW+:TW] = TW'(pu[0][c]);
      i_rd_cycle[c*TW+:TW] = TW'(cy[0][c]);
      i_cs_rd_setup[c*TW+:TW] = 0;
      i_cs_rd_pulse[c*TW+:TW] = TW'(cy[0][c]);
      i_wr_setup[c*TW+:TW] = TW'(su[1][c]);
      i_wr_pulse[c*TW+:TW] = TW'(pu[1][c]);
      i_wr_cycle[c*TW+:TW] = TW'(cy[1][c]);
      i_cs_wr_setup[c*TW+:TW] = 0;
      i_cs_wr_pulse[c*TW+:TW] = TW'(cy[1][c]);
      i_float[c*4+:4] = 4'($urandom_range(3));
      i_page_size[c*2+:2] = 2'($urandom_range(3));
    end
  endtask
  // ********
  // one access: request, wait for done, compare
  // ********
  task automatic acc(input int cs, input int off, input bit w, input int sz, input logic [31:0] d);
    int nb, n, lat, bt, s, p, c, x, el;
    logic [31:0] e, m;
    nb = 1 << sz;
    m = nb == 4 ? 32'hffffffff : (32'h1 << (8 * nb)) - 1;
    @(negedge i_ref_clk);
    i_req = 1;
    i_write = w;
    i_size = sz[1:0];
    i_addr = {cs[2:0], off[25:0]};
    i_wdata = d & m;
    #1;
    n = 0;
    while (o_ready !== 1'b1 && n < 500) begin
      @(negedge i_ref_clk);
      #1;
      n++;
    end
    @(negedge i_ref_clk);
    i_req = 0;
    lat = 1;
    while (o_done !== 1'b1 && lat < 500) begin
      @(negedge i_ref_clk);
      lat++;
    end
    chk("error", o_error, cs > 5);
    if (cs > 5) begin
      chk("error latency", lat, 1);
      return;
    end
    bt = nb > (1 << i_bus_width[2*cs+:2]) ? nb >> i_bus_width[2*cs+:2] : 1;
    s = i_slow_clock ? 1 : su[w][cs];
    p = i_slow_clock ? 1 : pu[w][cs];
    c = i_slow_clock ? 3 : cy[w][cs];
    x = stl > p - 1 ? stl - p + 1 : 0;
    el = (i_page_mode[cs] && !w) ? c + x + (bt - 1) * p + 1 : bt * (c + x) + 1;
    chk("latency", lat, el);
    e = 0;
    for (int k = 0; k < nb; k++) begin
      if (w) mem[(off + k) & 1023] = d[8*k+:8];
      else e[8*k+:8] = mem[(off + k) & 1023];
    end
    if (!w) chk("rdata", o_rdata & m, e);
  endtask
  initial begin
    #(30000 * 5);
    error_cnt++;
    $display("watchdog expired");
    close_out;
  end
  initial begin
    int cs, sz;
    void'($urandom(6764));
    for (int i = 0; i < 1024; i++) mem[i] = i[7:0] ^ 8'h5a;
    cfg;
    repeat (12) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_rstn = 1;
    for (int i = 0; i < 160; i++) begin
      if (i == 120) begin
        i_slow_clock = 1;
        i_page_mode = 0;
      end
      cs = $urandom_range(6);
      sz = $urandom_range(2);
      stl = (cs == 5 && i < 120) ? 2'h0 : 2'($urandom_range(3));
      acc(cs, ($urandom_range(1023) & ~((1 << sz) - 1)) | ($urandom_range(255) << 10),
          $urandom_range(1), sz, $urandom);
    end
    acc(7, 0, 0, 2, 0);
    close_out;
  end
endmodule
bind static_memory_bus_controller pin_rule_monitor #(.NUM_CS(NUM_CS)) mon (.*);
`default_nettype wire
